// File: hw/ocs_consts.vh
/*
 * Constants for the optical module channel control and status bank:
 * APB register offsets, field positions, reset values and code limits.
 * Assumes byte addressing on a 32-bit APB and ten lanes per direction.
 */
`ifndef OCS_CONSTS_VH
`define OCS_CONSTS_VH

// ==========================================================================
// Geometry
`define OCS_NCH            10
`define OCS_ADDR_W         8

// ==========================================================================
// Register byte offsets
`define OCS_TX_CTRL        8'h00
`define OCS_RX_CTRL        8'h04
`define OCS_TX_EQ_LO       8'h08
`define OCS_TX_EQ_HI       8'h0C
`define OCS_RX_DE_LO       8'h10
`define OCS_RX_DE_HI       8'h14
`define OCS_RX_AMP_LO      8'h18
`define OCS_RX_AMP_HI      8'h1C
`define OCS_TX_FLAG        8'h20
`define OCS_RX_FLAG        8'h24
`define OCS_ALARM_FLAG     8'h28
`define OCS_TX_MASK        8'h2C
`define OCS_RX_MASK        8'h30
`define OCS_ALARM_MASK     8'h34
`define OCS_STATUS         8'h38
`define OCS_MON_BIAS       8'h3C
`define OCS_MON_LIGHT      8'h40
`define OCS_MON_TEMP_VCC   8'h44
`define OCS_MON_RXPWR      8'h48

// ==========================================================================
// Field positions inside the control words
`define OCS_POL_LSB        0
`define OCS_DEACT_LSB      10
`define OCS_SQDIS_LSB      20
`define OCS_TXFLT_LSB      10

// ==========================================================================
// Reset values and code limits
`define OCS_CTRL_RST       32'h00000000
`define OCS_CODE_RST       4'h0
`define OCS_MASK_RST       20'h00000
`define OCS_CODE_MAX       4'h7

`endif

// File: hw/ocs_ctrl_status.v
/*
 * Channel control and status register bank of a ten-lane optical module,
 * reached over APB. Holds per-lane controls, live monitor views and latched
 * clear-on-read flags that drive one maskable interrupt line.
 * Assumes lane detectors, fault detectors, alarm comparators and monitor
 * ADC words arrive synchronous to clk from the analog front end.
 */
// Operation
// [R1] Ten independent transmit and receive channels
// [R2] Flags latch and stay set
// [R3] Reading flag register clears its flags
// [R4] Each source maskable, flag still latches
// [R5] Unmasked set flag raises interrupt output
// [R6] Threshold crossing sets alarm flag, requests interrupt
// [R7] Tx loss and fault flags per channel
// [R8] Rx optical loss flag per channel
// [R9] Tx loss squelches output unless disabled
// [R10] Tx squelch uses loss detector threshold
// [R11] Fault or deactivation disables Tx channel
// [R12] Rx squelch on loss or deactivation
// [R13] Tx polarity, deactivate, squelch disable, equalization
// [R14] Rx polarity, deactivate, squelch, amplitude, de-emphasis
// [R15] Four-bit Tx equalization code per channel
// [R16] Equalization codes with top bit reserved
// [R17] Four-bit Rx de-emphasis code per channel
// [R18] De-emphasis codes with top bit reserved
// [R19] Bias, light power, temperature, supply readable; only bits [31:0] of bias and light power, lanes 0-3, are readable
// [R20] Rx optical power readable per channel; only mon_rx_power[31:0], lanes 0-3, is readable
// [R21] Status, alarm, fault readable by host
// [R22] Interrupt drops when no unmasked flag
// [R23] Host never writes reserved codes
`timescale 1ns/1ps
`default_nettype none
`include "ocs_consts.vh"

module ocs_ctrl_status (
    input  wire        clk,
    input  wire        reset,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    input  wire [9:0]  tx_signal_loss,
    input  wire [9:0]  tx_fault,
    input  wire [9:0]  rx_signal_loss,
    input  wire [19:0] alarm_cond,
    input  wire [79:0] mon_bias,
    input  wire [79:0] mon_light_output_power,
    input  wire [79:0] mon_rx_power,
    input  wire [7:0]  mon_temp,
    input  wire [7:0]  mon_vcc,
    output reg  [9:0]  tx_pol_flip,
    output reg  [9:0]  tx_enable,
    output reg  [9:0]  rx_pol_flip,
    output reg  [9:0]  rx_out_enable,
    output reg  [39:0] tx_eq_code,
    output reg  [39:0] rx_deemph_code,
    output reg  [39:0] rx_amp_code,
    output reg         int_n
);

    // ======================================================================
    // Bus decode
    wire        acc   = psel & penable;
    wire        wr_en = acc & pwrite;
    wire        rd_en = acc & ~pwrite;

    reg         hit;
    always @* begin
        case (paddr)
            `OCS_TX_CTRL, `OCS_RX_CTRL, `OCS_TX_EQ_LO, `OCS_TX_EQ_HI,
            `OCS_RX_DE_LO, `OCS_RX_DE_HI, `OCS_RX_AMP_LO, `OCS_RX_AMP_HI,
            `OCS_TX_FLAG, `OCS_RX_FLAG, `OCS_ALARM_FLAG, `OCS_TX_MASK,
            `OCS_RX_MASK, `OCS_ALARM_MASK, `OCS_STATUS, `OCS_MON_BIAS,
            `OCS_MON_LIGHT, `OCS_MON_TEMP_VCC, `OCS_MON_RXPWR: hit = 1'b1;
            default: hit = 1'b0;
        endcase
    end

    // Zero wait states; unmapped addresses answer with an error
    assign pready  = 1'b1;
    assign pslverr = acc & ~hit;

    // ======================================================================
    // Control registers
    reg  [31:0] tx_ctrl;
    reg  [31:0] rx_ctrl;
    reg  [39:0] tx_eq;
    reg  [39:0] rx_de;
    reg  [39:0] rx_amp;
    reg  [19:0] tx_mask;
    reg  [9:0]  rx_mask;
    reg  [19:0] alarm_mask;

    always @(posedge clk or posedge reset) begin
        if (reset) begin
            tx_ctrl    <= `OCS_CTRL_RST;
            rx_ctrl    <= `OCS_CTRL_RST;
            tx_eq      <= {10{`OCS_CODE_RST}};
            rx_de      <= {10{`OCS_CODE_RST}};
            rx_amp     <= {10{`OCS_CODE_RST}};
            tx_mask    <= `OCS_MASK_RST;
            rx_mask    <= 10'h000;
            alarm_mask <= `OCS_MASK_RST;
        end else if (wr_en) begin
            case (paddr)
                `OCS_TX_CTRL:    tx_ctrl <= {2'b00, pwdata[29:0]};     // R13
                `OCS_RX_CTRL:    rx_ctrl <= {2'b00, pwdata[29:0]};     // R14
                `OCS_TX_EQ_LO:   tx_eq[31:0] <= pwdata;                // R15
                `OCS_TX_EQ_HI:   tx_eq[39:32] <= pwdata[7:0];          // R15
                `OCS_RX_DE_LO:   rx_de[31:0] <= pwdata;                // R17
                `OCS_RX_DE_HI:   rx_de[39:32] <= pwdata[7:0];          // R17
                `OCS_RX_AMP_LO:  rx_amp[31:0] <= pwdata;               // R14
                `OCS_RX_AMP_HI:  rx_amp[39:32] <= pwdata[7:0];         // R14
                `OCS_TX_MASK:    tx_mask <= pwdata[19:0];              // R4
                `OCS_RX_MASK:    rx_mask <= pwdata[9:0];               // R4
                `OCS_ALARM_MASK: alarm_mask <= pwdata[19:0];           // R4
                default: ;
            endcase
        end
    end

    // ======================================================================
    // Lane outputs, one instance per lane
    genvar g;
    generate
        for (g = 0; g < `OCS_NCH; g = g + 1) begin : lane                  // R1
            wire [3:0] eq = tx_eq[4*g+3:4*g];
            wire [3:0] de = rx_de[4*g+3:4*g];
            always @(posedge clk or posedge reset) begin
                if (reset) begin
                    tx_pol_flip[g]          <= 1'b0;
                    rx_pol_flip[g]          <= 1'b0;
                    tx_enable[g]            <= 1'b0;
                    rx_out_enable[g]        <= 1'b0;
                    tx_eq_code[4*g+3:4*g]   <= `OCS_CODE_RST;
                    rx_deemph_code[4*g+3:4*g] <= `OCS_CODE_RST;
                    rx_amp_code[4*g+3:4*g]  <= `OCS_CODE_RST;
                end else begin
                    tx_pol_flip[g] <= tx_ctrl[`OCS_POL_LSB+g];                    // R13
                    rx_pol_flip[g] <= rx_ctrl[`OCS_POL_LSB+g];                    // R14
                    // Same loss detector feeds squelch and flag
                    tx_enable[g] <= ~tx_fault[g] & ~tx_ctrl[`OCS_DEACT_LSB+g]      // R11
                        & ~(tx_signal_loss[g] & ~tx_ctrl[`OCS_SQDIS_LSB+g]);      // R9 R10
                    rx_out_enable[g] <= ~rx_ctrl[`OCS_DEACT_LSB+g]
                        & ~(rx_signal_loss[g] & ~rx_ctrl[`OCS_SQDIS_LSB+g]);      // R12
                    // A reserved code is clamped to full scale so the lane never sees it
                    tx_eq_code[4*g+3:4*g] <= eq[3] ? `OCS_CODE_MAX : eq;          // R16
                    rx_deemph_code[4*g+3:4*g] <= de[3] ? `OCS_CODE_MAX : de;      // R18
                    rx_amp_code[4*g+3:4*g] <= rx_amp[4*g+3:4*g];                  // R14
                end
            end
        end
    endgenerate

    // ======================================================================
    // Latched flags, cleared on read; a new event in the read cycle wins
    reg  [19:0] tx_flag;
    reg  [9:0]  rx_flag;
    reg  [19:0] alarm_flag;
    wire [19:0] tx_ev = {tx_fault, tx_signal_loss};                             // R7

    always @(posedge clk or posedge reset) begin
        if (reset) begin
            tx_flag    <= 20'h00000;
            rx_flag    <= 10'h000;
            alarm_flag <= 20'h00000;
        end else begin
            tx_flag <= ((rd_en && paddr == `OCS_TX_FLAG) ? 20'h00000 : tx_flag)
                       | tx_ev;                                                 // R2 R3
            rx_flag <= ((rd_en && paddr == `OCS_RX_FLAG) ? 10'h000 : rx_flag)
                       | rx_signal_loss;                                        // R8 R2 R3
            alarm_flag <= ((rd_en && paddr == `OCS_ALARM_FLAG) ? 20'h00000 : alarm_flag)
                          | alarm_cond;                                         // R6 R2 R3
        end
    end

    // Interrupt is a registered active-low output driven high and low; masked bits still latch
    wire irq = |(tx_flag & ~tx_mask) | |(rx_flag & ~rx_mask)
               | |(alarm_flag & ~alarm_mask);                                   // R4 R5
    always @(posedge clk or posedge reset) begin
        if (reset)
            int_n <= 1'b1;
        else
            int_n <= ~irq;                                                      // R5 R22
    end

    // ======================================================================
    // Read data
    always @* begin
        prdata = 32'h00000000;
        if (rd_en) begin
            case (paddr)
                `OCS_TX_CTRL:      prdata = tx_ctrl;
                `OCS_RX_CTRL:      prdata = rx_ctrl;
                `OCS_TX_EQ_LO:     prdata = tx_eq[31:0];
                `OCS_TX_EQ_HI:     prdata = {24'h000000, tx_eq[39:32]};
                `OCS_RX_DE_LO:     prdata = rx_de[31:0];
                `OCS_RX_DE_HI:     prdata = {24'h000000, rx_de[39:32]};
                `OCS_RX_AMP_LO:    prdata = rx_amp[31:0];
                `OCS_RX_AMP_HI:    prdata = {24'h000000, rx_amp[39:32]};
                `OCS_TX_FLAG:      prdata = {12'h000, tx_flag};                 // R21
                `OCS_RX_FLAG:      prdata = {22'h0, rx_flag};                   // R21
                `OCS_ALARM_FLAG:   prdata = {12'h000, alarm_flag};              // R21
                `OCS_TX_MASK:      prdata = {12'h000, tx_mask};
                `OCS_RX_MASK:      prdata = {22'h0, rx_mask};
                `OCS_ALARM_MASK:   prdata = {12'h000, alarm_mask};
                `OCS_STATUS:       prdata = {2'b00, rx_signal_loss, tx_fault,
                                             tx_signal_loss};                   // R21
                `OCS_MON_BIAS:     prdata = mon_bias[31:0];                     // R19
                `OCS_MON_LIGHT:    prdata = mon_light_output_power[31:0];       // R19
                `OCS_MON_TEMP_VCC: prdata = {16'h0000, mon_vcc, mon_temp};      // R19
                `OCS_MON_RXPWR:    prdata = mon_rx_power[31:0];                 // R20
                default:           prdata = 32'h00000000;
            endcase
        end
    end

endmodule // ocs_ctrl_status
`default_nettype wire

// File: testbench/ocs_ctrl_props.sv
/* Checker for ocs_ctrl_status, watching its ports only.
   Assumes zero-wait APB and detector inputs synchronous to clk. */
`timescale 1ns/1ps
`default_nettype none
module ocs_ctrl_props (
    input wire logic        clk,
    input wire logic        reset,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [9:0]  tx_signal_loss,
    input wire logic [9:0]  tx_fault,
    input wire logic [9:0]  rx_signal_loss,
    input wire logic [79:0] mon_bias,
    input wire logic [79:0] mon_rx_power,
    input wire logic [9:0]  tx_pol_flip,
    input wire logic [9:0]  tx_enable,
    input wire logic        int_n
);
// ==========================================
// Properties
default clocking cb @(posedge clk); endclocking
default disable iff (reset);
wire acc = psel && penable;
wire rd  = acc && !pwrite;
AST_READY: assert property (pready) else $error("pready low");
AST_SLVERR: assert property (acc && paddr > 8'h48 |-> pslverr) else $error("no slverr");
AST_IDLE: assert property (!rd |-> prdata == 32'h0) else $error("prdata not idle");
AST_UNMAP: assert property (rd && paddr > 8'h48 |-> prdata == 32'h0) else $error("unmapped");
AST_STATUS: assert property (rd && paddr == 8'h38 |->
    prdata == {2'h0, rx_signal_loss, tx_fault, tx_signal_loss}) else $error("status");
AST_BIAS: assert property (rd && paddr == 8'h3C |-> prdata == mon_bias[31:0]) else $error("bias");
AST_RXPWR: assert property (rd && paddr == 8'h48 |-> prdata == mon_rx_power[31:0]) else $error("rxpwr");
AST_FAULT: assert property (|tx_fault |=> (tx_enable & $past(tx_fault)) == 10'h0) else $error("fault");
AST_POL: assert property (acc && pwrite && paddr == 8'h00 |=> ##1
    tx_pol_flip == $past(pwdata[9:0], 2)) else $error("polarity");
COV_FLAG: cover property (rd && paddr == 8'h20 && prdata != 32'h0);
COV_ERR: cover property (acc && pslverr);
COV_INT: cover property ($fell(int_n));
endmodule // ocs_ctrl_props
bind ocs_ctrl_status ocs_ctrl_props u_ocs_ctrl_props (.clk, .reset, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .tx_signal_loss, .tx_fault, .rx_signal_loss,
    .mon_bias, .mon_rx_power, .tx_pol_flip, .tx_enable, .int_n);
`default_nettype wire

// File: testbench/ocs_front_model.sv
/* Front-end model: lane detectors, alarm comparators, monitor words.
   Assumes the bench requests events just after a rising edge. */
`timescale 1ns/1ps
`default_nettype none
module ocs_front_model (
    input  wire logic        clk,
    input  wire logic [9:0]  ev_tl,
    input  wire logic [9:0]  ev_tf,
    input  wire logic [9:0]  ev_rl,
    input  wire logic [19:0] ev_al,
    input  wire logic [31:0] ms,
    output var  logic [9:0]  tx_signal_loss,
    output var  logic [9:0]  tx_fault,
    output var  logic [9:0]  rx_signal_loss,
    output var  logic [19:0] alarm_cond,
    output var  logic [79:0] mon_bias,
    output var  logic [79:0] mon_light_output_power,
    output var  logic [79:0] mon_rx_power,
    output var  logic [7:0]  mon_temp,
    output var  logic [7:0]  mon_vcc
);
// Detectors resync to clk, so events reach the bank one edge late
always @(posedge clk) begin
    tx_signal_loss <= ev_tl;
    tx_fault       <= ev_tf;
    rx_signal_loss <= ev_rl;
    alarm_cond     <= ev_al;
end
assign mon_bias               = {ms[15:0], ms, ms};
assign mon_light_output_power = ~{ms[15:0], ms, ms};
assign mon_rx_power           = {ms[15:0], ms, ms ^ 32'h5A5A5A5A};
assign mon_temp               = ms[7:0];
assign mon_vcc                = ms[15:8];
endmodule // ocs_front_model
`default_nettype wire

// File: testbench/tb.sv
/* Self-checking bench for ocs_ctrl_status: APB master, front-end model.
   Assumes the checker is bound from its own file. */
`timescale 1ns/1ps
`default_nettype none
`include "ocs_consts.vh"
module tb;
logic        clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, int_n;
logic [7:0]  paddr = 8'h00, a;
logic [9:0]  tl = 0, tf = 0, rl = 0, e10, tx_pol_flip, tx_enable, rx_pol_flip, rx_out_enable;
logic [19:0] al = 0, alarm_cond;
logic [31:0] pwdata = 0, ms = 0, seed = 32'h0321, prdata, r, w, v, ex[4];
logic [39:0] c, g40, tx_eq_code, rx_deemph_code, rx_amp_code;
logic [9:0]  tx_signal_loss, tx_fault, rx_signal_loss;
logic [79:0] mon_bias, mon_light_output_power, mon_rx_power;
logic [7:0]  mon_temp, mon_vcc;
int          error_cnt = 0, compares = 0;
always #50 clk = ~clk;
ocs_front_model u_ocs_front_model (.clk, .ev_tl(tl), .ev_tf(tf), .ev_rl(rl), .ev_al(al), .ms,
    .tx_signal_loss, .tx_fault, .rx_signal_loss, .alarm_cond, .mon_bias,
    .mon_light_output_power, .mon_rx_power, .mon_temp, .mon_vcc);
ocs_ctrl_status u_ocs_ctrl_status (.clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .tx_signal_loss, .tx_fault, .rx_signal_loss, .alarm_cond,
    .mon_bias, .mon_light_output_power, .mon_rx_power, .mon_temp, .mon_vcc, .tx_pol_flip,
    .tx_enable, .rx_pol_flip, .rx_out_enable, .tx_eq_code, .rx_deemph_code, .rx_amp_code, .int_n);
// ==========================================
// Helpers
function automatic logic [31:0] nx();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
endfunction
function automatic logic [39:0] sat(input logic [39:0] x);
    for (int k = 0; k < 10; k++) if (x[4*k+3]) x[4*k+:4] = 4'h7;
    return x;
endfunction
task automatic finish_test;
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
endtask
task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
        error_cnt++;
        $display("wrong value %s expected %h seen %h", nm, e, g);
    end
endtask
// Held until the edge that samples pready; read data taken there
task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] wd);
    int n;
    @(posedge clk);
    psel <= 1'b1; pwrite <= wr; paddr <= ad; pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 16);
    r = prdata;
    psel <= 1'b0; penable <= 1'b0;
    if (pready !== 1'b1) begin error_cnt++; finish_test(); end
endtask
// ==========================================
// Scenarios
initial begin
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    repeat (2) @(negedge clk);
    chk("int_n", 1, int_n);
    chk("tx_enable", 10'h3FF, tx_enable);
    apb(0, `OCS_TX_MASK, 0);
    chk("mask", 0, r);
    v = nx();
    tl <= v[9:0]; tf <= v[19:10]; rl <= v[29:20];
    for (int d = 0; d < 2; d++) begin
        w = nx();
        a = d ? `OCS_RX_CTRL : `OCS_TX_CTRL;
        apb(1, a, w);
        apb(0, a, 0);
        chk("ctrl", w & 32'h3FFFFFFF, r);
        repeat (2) @(negedge clk);
        e10 = ~w[19:10] & ~((d ? rl : tl) & ~w[29:20]) & ~(d ? 10'h0 : tf);
        chk("pol", w[9:0], d ? rx_pol_flip : tx_pol_flip);
        chk("enable", e10, d ? rx_out_enable : tx_enable);
    end
    apb(0, `OCS_STATUS, 0);
    chk("status", {2'h0, rl, tf, tl}, r);
    {tl, tf, rl} <= 30'h0;
    for (a = `OCS_TX_FLAG; a <= `OCS_ALARM_FLAG; a = a + 8'h04) apb(0, a, 0);
    for (int g = 0; g < 4; g++) begin
        for (int m = 0; m < 2; m++) begin
            v = nx() & (g == 3 ? 32'hFFFFF : 32'h3FF) | 32'h1;
            a = g < 2 ? `OCS_TX_FLAG : (g == 2 ? `OCS_RX_FLAG : `OCS_ALARM_FLAG);
            apb(1, a + 8'h0C, m ? 32'hFFFFF : 32'h0);
            @(posedge clk);
            case (g) 0: tl <= v[9:0]; 1: tf <= v[9:0]; 2: rl <= v[9:0]; default: al <= v[19:0]; endcase
            @(posedge clk);
            {tl, tf, rl, al} <= 50'h0;
            repeat (3) @(negedge clk);
            chk("int_n", m == 1, int_n);
            apb(0, a, 0);
            chk("flag", g == 1 ? v << 10 : v, r);
            apb(0, a, 0);
            chk("cleared", 0, r);
            @(negedge clk);
            chk("int_n", 1, int_n);
        end
    end
    for (int i = 0; i < 3; i++) begin
        w = nx() & 32'h77777777;
        a = i == 0 ? `OCS_TX_EQ_LO : (i == 1 ? `OCS_RX_DE_LO : `OCS_RX_AMP_LO);
        apb(1, a, w);
        apb(1, a + 8'h04, w);
        apb(0, a, 0);
        chk("code", w, r);
        repeat (2) @(negedge clk);
        c = i < 2 ? sat({w[7:0], w}) : {w[7:0], w};
        g40 = i == 0 ? tx_eq_code : (i == 1 ? rx_deemph_code : rx_amp_code);
        chk("lane lo", c[31:0], g40[31:0]);
        chk("lane hi", {24'h0, c[39:32]}, {24'h0, g40[39:32]});
    end
    w = nx();
    ms <= w;
    ex = '{w, ~w, {16'h0, w[15:0]}, w ^ 32'h5A5A5A5A};
    a = `OCS_MON_BIAS;
    for (int j = 0; j < 4; j++) begin
        apb(0, a, 0);
        chk("monitor", ex[j], r);
        a = a + 8'h04;
    end
    apb(1, 8'h4C, w);
    apb(0, 8'h4C, 0);
    chk("unmapped", 0, r);
    finish_test();
end
endmodule // tb
`default_nettype wire
